// ### design/phy_link_pkg.sv
// package: constants for the link side of the phy-link interface
package phy_link_pkg;
    // control-line codes
    localparam logic [1:0] CTL_IDLE    = 2'h0;
    localparam logic [1:0] CTL_STATUS  = 2'h1;
    localparam logic [1:0] CTL_RECEIVE = 2'h2;
    localparam logic [1:0] CTL_HOLD    = 2'h1;
    localparam logic [1:0] CTL_XMIT    = 2'h2;
    // status stream layout
    localparam int STAT_BITS       = 16;
    localparam int STAT_ARB_GAP    = 0;
    localparam int STAT_FAIR_GAP   = 1;
    localparam int STAT_BUS_RESET  = 2;
    localparam int STAT_PHY_INT    = 3;
    localparam int STAT_ADDR_LO    = 4;
    localparam int STAT_DATA_LO    = 8;
    localparam logic [3:0] STAT_SHORT_PAIRS = 4'h2;
    localparam logic [3:0] STAT_FULL_PAIRS  = 4'h8;
    // receive speed codes
    localparam logic [7:0] DATA_ON   = 8'hff;
    localparam logic [1:0] SPD_S100  = 2'h0;
    localparam logic [1:0] SPD_S200  = 2'h1;
    localparam logic [1:0] SPD_S400  = 2'h2;
    localparam logic [1:0] SPD_BAD   = 2'h3;
    // apb register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PHYREG = 8'h08;
    localparam logic [7:0] REG_TXDATA = 8'h0c;
    localparam logic [7:0] REG_RXDATA = 8'h10;
    localparam logic [7:0] REG_TXCTL  = 8'h14;
    // ctrl register fields
    localparam int CTRL_READ_PEND = 0;
    localparam int CTRL_HOLD_EN   = 1;
    // txctl register fields
    localparam int TXC_LAST  = 8;
    localparam int TXC_MORE  = 9;
    localparam int TXC_SPD_LO = 10;
    // status register bit positions; only bits 0 to 6 are sticky
    localparam int ST_ARB    = 0;
    localparam int ST_FAIR   = 1;
    localparam int ST_RESET  = 2;
    localparam int ST_INT    = 3;
    localparam int ST_FULL   = 4;
    localparam int ST_RXVAL  = 5;
    localparam int ST_TXRDY  = 6;
    localparam int ST_RXSPD_LO = 8;
    localparam int ST_RXACT  = 10;
    localparam int ST_TXBUSY = 11;
endpackage : phy_link_pkg

// ### design/status_shifter.sv
// status transfer deserialiser: two bits per clock on the low data lines
`timescale 1ns/1ps
module status_shifter (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [1:0]  ctl_in,
    input  wire logic [1:0]  dat_in,
    input  wire logic        full_expected_in,
    output logic             done_out,
    output logic             full_out,
    output logic [15:0]      word_out
);
    logic [3:0]  cnt_q;
    logic [15:0] sh_q;
    logic        active_w;
    logic [15:0] sh_d;
    logic [3:0]  cnt_d;
    logic        short_end_w;
    logic        full_end_w;

    // bits fill from bit 0 upward, two per clock
    assign active_w    = (ctl_in == phy_link_pkg::CTL_STATUS);
    assign sh_d        = sh_q | ({14'h0, dat_in} << {cnt_q, 1'b0});
    assign cnt_d       = cnt_q + 4'h1;
    // short transfer ends when ctl leaves status after two pairs
    assign short_end_w = !active_w && (cnt_q == phy_link_pkg::STAT_SHORT_PAIRS);
    assign full_end_w  = active_w && (cnt_d == phy_link_pkg::STAT_FULL_PAIRS[3:0] - 4'h0)
                         && (cnt_q == 4'h7);

    // a full word may come unasked (new node id), so length is taken from ctl
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || full_end_w || !active_w) begin
            cnt_q <= 4'h0;
            sh_q  <= 16'h0;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
        end
    end

    // latch the completed word
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            full_out <= 1'b0;
            word_out <= 16'h0;
        end else begin
            done_out <= short_end_w || full_end_w;
            full_out <= full_end_w;
            if (full_end_w)
                word_out <= sh_d;
            else if (short_end_w)
                word_out <= {word_out[15:4], sh_q[3:0]};
        end
    end
    // full_expected_in is advisory only; a full word is accepted either way
    logic unused_w;
    assign unused_w = full_expected_in;
endmodule : status_shifter

// ### design/link_phy_if.sv
// link-side logic of the phy-link interface with apb registers
`timescale 1ns/1ps
module link_phy_if (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [1:0]  ctl_in,
    output logic [1:0]       ctl_out,
    output logic             ctl_oe_out,
    input  wire logic [7:0]  link_data_lines_in,
    output logic [7:0]       link_data_lines_out,
    output logic             data_oe_out,
    output logic             host_irq_out,
    output logic             busy_retry_gap_out,
    output logic             iso_cycle_done_out,
    output logic             bus_reset_out
);
    typedef enum {TX_IDLE, TX_WAIT_GRANT, TX_HOLD, TX_SEND, TX_END, TX_REL, TX_WAIT_XMIT} tx_state_t;
    typedef enum {RX_IDLE, RX_SPEED, RX_DATA} rx_state_t;

    // speed code classifier, used for rx decode only
    function automatic logic [1:0] speed_of(input logic [7:0] c);
        if (c[7:6] == 2'h0)
            speed_of = phy_link_pkg::SPD_S100;
        else if (c[7:4] == 4'h4)
            speed_of = phy_link_pkg::SPD_S200;
        else if (c == 8'h50)
            speed_of = phy_link_pkg::SPD_S400;
        else
            speed_of = phy_link_pkg::SPD_BAD;
    endfunction : speed_of

    tx_state_t   tx_q;
    rx_state_t   rx_q;
    logic [11:0] sticky_q;
    logic [15:0] phyreg_q;
    logic        read_pend_q;
    logic        hold_en_q;
    logic [7:0]  tx_byte_q;
    logic        tx_valid_q;
    logic        tx_last_q;
    logic        tx_more_q;
    logic [1:0]  tx_spd_q;
    logic [1:0]  grant_spd_q;
    logic [7:0]  rx_byte_q;
    logic [1:0]  rx_spd_q;

    logic        st_done_w;
    logic        st_full_w;
    logic [15:0] st_word_w;

    // own hold/transmit codes on the shared lines are not phy traffic
    logic [1:0]  phy_ctl_w;
    assign phy_ctl_w = ctl_oe_out ? phy_link_pkg::CTL_IDLE : ctl_in;

    status_shifter u_status (
        .sys_clk_in       (sys_clk_in),
        .rst_n_in         (rst_n_in),
        .ctl_in           (phy_ctl_w),
        .dat_in           (link_data_lines_in[1:0]),
        .full_expected_in (read_pend_q),
        .done_out         (st_done_w),
        .full_out         (st_full_w),
        .word_out         (st_word_w)
    );

    // apb decode: zero wait states, pslverr on unmapped offsets
    logic wr_w;
    logic rd_acc_w;
    logic hit_w;
    logic wr_ctrl_w;
    logic wr_stat_w;
    logic wr_tx_w;
    logic rd_rx_w;
    logic tx_take_w;
    logic [31:0] rdata_w;
    assign hit_w     = (paddr_in == phy_link_pkg::REG_CTRL)   || (paddr_in == phy_link_pkg::REG_STATUS)
                    || (paddr_in == phy_link_pkg::REG_PHYREG) || (paddr_in == phy_link_pkg::REG_TXDATA)
                    || (paddr_in == phy_link_pkg::REG_RXDATA) || (paddr_in == phy_link_pkg::REG_TXCTL);
    assign wr_w      = psel_in && penable_in && pwrite_in && hit_w;
    assign rd_acc_w  = psel_in && penable_in && !pwrite_in;
    assign wr_ctrl_w = wr_w && (paddr_in == phy_link_pkg::REG_CTRL);
    assign wr_stat_w = wr_w && (paddr_in == phy_link_pkg::REG_STATUS);
    assign wr_tx_w   = wr_w && (paddr_in == phy_link_pkg::REG_TXCTL) && !tx_valid_q;
    assign rd_rx_w   = rd_acc_w && (paddr_in == phy_link_pkg::REG_RXDATA);
    assign rdata_w   = (paddr_in == phy_link_pkg::REG_CTRL)   ? {30'h0, hold_en_q, read_pend_q} :
                       (paddr_in == phy_link_pkg::REG_STATUS) ? {20'h0, sticky_q} :
                       (paddr_in == phy_link_pkg::REG_PHYREG) ? {16'h0, phyreg_q} :
                       (paddr_in == phy_link_pkg::REG_TXDATA) ? {24'h0, tx_byte_q} :
                       (paddr_in == phy_link_pkg::REG_RXDATA) ? {24'h0, rx_byte_q} :
                       (paddr_in == phy_link_pkg::REG_TXCTL)  ? {20'h0, tx_spd_q, tx_more_q, tx_last_q, tx_byte_q}
                                                              : 32'h0;

    // apb answer registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !hit_w;
            prdata_out  <= rdata_w;
        end
    end

    // control bits; the read-pending flag drops when a full status arrives
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            read_pend_q <= 1'b0;
            hold_en_q   <= 1'b0;
        end else begin
            if (wr_ctrl_w) begin
                read_pend_q <= pwdata_in[phy_link_pkg::CTRL_READ_PEND];
                hold_en_q   <= pwdata_in[phy_link_pkg::CTRL_HOLD_EN];
            end else if (st_full_w) begin
                read_pend_q <= 1'b0;
            end
        end
    end

    // status flags from the phy; a set in the clearing cycle wins
    logic [3:0]  flag_set_w;
    logic [11:0] set_w;
    logic        rx_byte_set_w;
    assign flag_set_w    = st_done_w ? st_word_w[3:0] : 4'h0;
    assign rx_byte_set_w = (rx_q == RX_DATA) && (phy_ctl_w == phy_link_pkg::CTL_RECEIVE);
    assign set_w = {2'b00, 2'b00, 1'b0, tx_valid_q == 1'b0, rx_byte_set_w, st_full_w, flag_set_w};

    // sticky status register with write-one-to-clear on low seven bits
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sticky_q <= 12'h0;
        end else begin
            sticky_q[6:0] <= (sticky_q[6:0] & ~((wr_stat_w ? pwdata_in[6:0] : 7'h0)
                             | (rd_rx_w ? 7'h20 : 7'h0))) | set_w[6:0];
            sticky_q[7]   <= 1'b0;
            sticky_q[9:8] <= rx_spd_q;
            sticky_q[10]  <= (rx_q != RX_IDLE);
            sticky_q[11]  <= (tx_q != TX_IDLE);
        end
    end

    // register address and contents from a full status word
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in)
            phyreg_q <= 16'h0;
        else if (st_full_w)
            phyreg_q <= {st_word_w[15:8], 4'h0, st_word_w[7:4]};
    end

    // event outputs to the link core, one-cycle pulses except host_irq_out, which also follows the sticky interrupt bit
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            busy_retry_gap_out <= 1'b0;
            iso_cycle_done_out <= 1'b0;
            bus_reset_out      <= 1'b0;
            host_irq_out       <= 1'b0;
        end else begin
            busy_retry_gap_out <= flag_set_w[phy_link_pkg::STAT_ARB_GAP];
            iso_cycle_done_out <= flag_set_w[phy_link_pkg::STAT_FAIR_GAP];
            bus_reset_out      <= flag_set_w[phy_link_pkg::STAT_BUS_RESET];
            host_irq_out       <= sticky_q[phy_link_pkg::ST_INT] || flag_set_w[phy_link_pkg::STAT_PHY_INT];
        end
    end

    // receive path: data-on, speed code, then packet bytes
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rx_q      <= RX_IDLE;
            rx_byte_q <= 8'h0;
            rx_spd_q  <= phy_link_pkg::SPD_S100;
        end else begin
            case (rx_q)
                RX_IDLE: begin
                    if (phy_ctl_w == phy_link_pkg::CTL_RECEIVE && link_data_lines_in == phy_link_pkg::DATA_ON)
                        rx_q <= RX_SPEED;
                end
                RX_SPEED: begin
                    if (phy_ctl_w != phy_link_pkg::CTL_RECEIVE) begin
                        rx_q <= RX_IDLE;
                    end else if (link_data_lines_in != phy_link_pkg::DATA_ON) begin
                        rx_spd_q <= speed_of(link_data_lines_in);
                        rx_q     <= RX_DATA; // speed byte never reaches rx data
                    end
                end
                RX_DATA: begin
                    if (phy_ctl_w != phy_link_pkg::CTL_RECEIVE)
                        rx_q <= RX_IDLE;
                    else
                        rx_byte_q <= link_data_lines_in;
                end
                default: rx_q <= RX_IDLE;
            endcase
        end
    end

    // transmit path: grant, optional hold, bytes, idle or hold for next
    logic grant_w;
    assign grant_w   = (ctl_in == phy_link_pkg::CTL_XMIT);
    assign tx_take_w = (tx_q == TX_SEND) && tx_valid_q;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tx_valid_q <= 1'b0;
            tx_byte_q  <= 8'h0;
            tx_last_q  <= 1'b0;
            tx_more_q  <= 1'b0;
            tx_spd_q   <= phy_link_pkg::SPD_S100;
        end else if (wr_tx_w) begin
            tx_valid_q <= 1'b1;
            tx_byte_q  <= pwdata_in[7:0];
            tx_last_q  <= pwdata_in[phy_link_pkg::TXC_LAST];
            tx_more_q  <= pwdata_in[phy_link_pkg::TXC_MORE];
            tx_spd_q   <= pwdata_in[phy_link_pkg::TXC_SPD_LO +: 2];
        end else if (tx_take_w) begin
            tx_valid_q <= 1'b0;
        end
    end

    logic spd_ok_w;
    assign spd_ok_w = (tx_spd_q == grant_spd_q);

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tx_q                <= TX_IDLE;
            ctl_out             <= phy_link_pkg::CTL_IDLE;
            ctl_oe_out          <= 1'b0;
            data_oe_out         <= 1'b0;
            link_data_lines_out <= 8'h0;
            grant_spd_q         <= phy_link_pkg::SPD_S100;
        end else begin
            case (tx_q)
                TX_IDLE: begin
                    ctl_oe_out  <= 1'b0;
                    data_oe_out <= 1'b0;
                    if (tx_valid_q)
                        tx_q <= TX_WAIT_GRANT;
                end
                TX_WAIT_GRANT: begin
                    if (grant_w && rx_q == RX_IDLE) begin
                        grant_spd_q <= tx_spd_q;
                        ctl_oe_out  <= 1'b1;
                        data_oe_out <= 1'b1;
                        ctl_out     <= hold_en_q ? phy_link_pkg::CTL_HOLD : phy_link_pkg::CTL_XMIT;
                        tx_q        <= hold_en_q ? TX_HOLD : TX_SEND;
                    end
                end
                TX_HOLD: begin
                    // phy keeps the serial bus reserved meanwhile
                    ctl_out <= phy_link_pkg::CTL_XMIT;
                    tx_q    <= TX_SEND;
                end
                TX_SEND: begin
                    ctl_out <= phy_link_pkg::CTL_XMIT;
                    if (tx_valid_q && spd_ok_w) begin
                        link_data_lines_out <= tx_byte_q; // eight bits per cycle
                        if (tx_last_q)
                            tx_q <= TX_END; // transmit stands while the last byte is out
                    end
                end
                TX_END: begin
                    // one idle cycle, or hold to keep the bus for the next packet
                    ctl_out             <= tx_more_q ? phy_link_pkg::CTL_HOLD : phy_link_pkg::CTL_IDLE;
                    link_data_lines_out <= 8'h0;
                    tx_q                <= tx_more_q ? TX_WAIT_XMIT : TX_REL;
                end
                TX_REL: begin
                    // release after the idle cycle; the phy then idles itself
                    ctl_oe_out  <= 1'b0;
                    data_oe_out <= 1'b0;
                    tx_q        <= TX_IDLE;
                end
                TX_WAIT_XMIT: begin
                    // release ctl so the phy can assert transmit after its wait
                    ctl_oe_out <= 1'b0;
                    if (!ctl_oe_out && grant_w) begin
                        ctl_oe_out <= 1'b1;
                        ctl_out    <= phy_link_pkg::CTL_XMIT;
                        tx_q       <= TX_SEND;
                    end
                end
                default: tx_q <= TX_IDLE;
            endcase
        end
    end

    // checks
    idle_after_last_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (tx_q == TX_SEND && tx_valid_q && spd_ok_w && tx_last_q && !tx_more_q)
        |=> ctl_out == phy_link_pkg::CTL_XMIT
        ##1 (ctl_out == phy_link_pkg::CTL_IDLE && ctl_oe_out) ##1 !ctl_oe_out)
        else $error("idle not driven one cycle after last byte");
    hold_after_last_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (tx_q == TX_SEND && tx_valid_q && spd_ok_w && tx_last_q && tx_more_q)
        |=> ctl_out == phy_link_pkg::CTL_XMIT ##1 (ctl_out == phy_link_pkg::CTL_HOLD && ctl_oe_out))
        else $error("hold not driven between packets");
    grant_take_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (tx_q == TX_WAIT_GRANT && grant_w && rx_q == RX_IDLE)
        |=> ctl_oe_out && (ctl_out == phy_link_pkg::CTL_HOLD || ctl_out == phy_link_pkg::CTL_XMIT))
        else $error("grant not taken with hold or transmit");
    no_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (tx_q == TX_WAIT_GRANT && grant_w && rx_q == RX_IDLE && !hold_en_q) |=> tx_q == TX_SEND)
        else $error("transmit not entered directly");
    same_speed_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (tx_q == TX_SEND && tx_valid_q && tx_spd_q != grant_spd_q) |=> $stable(link_data_lines_out))
        else $error("byte sent at a speed other than the granted one");
    speed_dec_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (rx_q == RX_SPEED && phy_ctl_w == phy_link_pkg::CTL_RECEIVE && link_data_lines_in == 8'h50)
        |=> rx_spd_q == phy_link_pkg::SPD_S400 && rx_q == RX_DATA)
        else $error("speed code misdecoded");
    bus_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (st_done_w && st_word_w[2]) |=> bus_reset_out ##1 sticky_q[phy_link_pkg::ST_RESET])
        else $error("bus reset flag lost");
    irq_fwd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (st_done_w && st_word_w[3]) |=> host_irq_out)
        else $error("phy interrupt not forwarded");
    full_capture_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        st_full_w |=> phyreg_q[3:0] == $past(st_word_w[7:4]) && !read_pend_q)
        else $error("full status not captured");

    tx_hold_c: cover property (@(posedge sys_clk_in) tx_q == TX_HOLD);
    tx_concat_c: cover property (@(posedge sys_clk_in) tx_q == TX_WAIT_XMIT ##[1:20] tx_q == TX_SEND);
    rx_pkt_c: cover property (@(posedge sys_clk_in) rx_q == RX_SPEED ##1 rx_q == RX_DATA);
    full_stat_c: cover property (@(posedge sys_clk_in) st_full_w);
endmodule : link_phy_if

// ### verification/phy_model.sv
// partner model: physical layer side of the link interface
`timescale 1ns/1ps
module phy_model (
    input  wire logic  sys_clk_in,
    output logic [1:0] ctl_out,
    output logic [7:0] dat_out
);
    logic       drive_q = 1'b0;
    logic [7:0] val_q   = 8'h00;
    logic [7:0] spin_q  = 8'h5a;
    initial ctl_out = phy_link_pkg::CTL_IDLE;
    // released data lines toggle so a stale byte never looks valid
    always @(posedge sys_clk_in) spin_q <= ~spin_q;
    assign dat_out = drive_q ? val_q : spin_q;
    // one driven cycle on control and data lines
    task automatic step(input logic [1:0] c, input logic [7:0] d);
        ctl_out <= c;
        drive_q <= 1'b1;
        val_q   <= d;
        @(posedge sys_clk_in);
    endtask : step
    // idle control, data released; also keeps the bus reserved while the link owns it
    task automatic rest();
        ctl_out <= phy_link_pkg::CTL_IDLE;
        drive_q <= 1'b0;
        @(posedge sys_clk_in);
    endtask : rest
    // status, two bits a cycle on the low lines, then an idle gap
    task automatic status(input logic [15:0] w, input int pairs);
        for (int i = 0; i < pairs; i++) begin
            step(phy_link_pkg::CTL_STATUS, {6'h00, w[2*i+1], w[2*i]});
        end
        rest();
    endtask : status
    // grant after a won arbitration, one cycle of transmit code
    task automatic grant();
        ctl_out <= phy_link_pkg::CTL_XMIT;
        @(posedge sys_clk_in);
        rest();
    endtask : grant
    // data-on, speed code, one byte, then idle
    task automatic rx(input logic [7:0] receive_speed_code, input logic [7:0] b);
        step(phy_link_pkg::CTL_RECEIVE, phy_link_pkg::DATA_ON);
        step(phy_link_pkg::CTL_RECEIVE, receive_speed_code);
        step(phy_link_pkg::CTL_RECEIVE, b);
        rest();
    endtask : rx
endmodule : phy_model

// ### verification/tb_top.sv
// self-checking bench for the link side of the phy-link interface
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0, prdata, rd;
    logic        pready, pslverr, er, ctl_oe, data_oe, irq, gap_p, iso_p, rst_p;
    logic [1:0]  ctl_out, phy_ctl, ctl_w;
    logic [7:0]  dat_out, phy_dat, dat_w;
    logic [3:0]  hits    = 4'h0;
    int          err_total = 0, cmp_count = 0, n;
    always #50 sys_clk = ~sys_clk;
    // the wire follows whichever side has its enable up
    assign ctl_w = ctl_oe ? ctl_out : phy_ctl;
    assign dat_w = data_oe ? dat_out : phy_dat;
    // gap, iso and reset pulses last one cycle, so gather them and irq between checks
    always @(posedge sys_clk) hits <= (clr ? 4'h0 : hits) | {irq, rst_p, iso_p, gap_p};
    link_phy_if u_link_phy_if (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .ctl_in(ctl_w), .ctl_out(ctl_out), .ctl_oe_out(ctl_oe),
        .link_data_lines_in(dat_w), .link_data_lines_out(dat_out), .data_oe_out(data_oe),
        .host_irq_out(irq), .busy_retry_gap_out(gap_p), .iso_cycle_done_out(iso_p), .bus_reset_out(rst_p));
    phy_model u_phy_model (.sys_clk_in(sys_clk), .ctl_out(phy_ctl), .dat_out(phy_dat));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one edge under a bound; a hang ends the run as a failure
    task automatic tick();
        @(posedge sys_clk);
        n++;
        if (n > 300) begin
            err_total++;
            report_and_stop();
        end
    endtask : tick
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do tick(); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this step
        @(posedge sys_clk);
    endtask : apb
    // clear collected pulses, send one status, compare what fired
    task automatic flags(input logic [15:0] w, input int pairs, input logic [3:0] exp);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        u_phy_model.status(w, pairs);
        repeat (4) @(posedge sys_clk);
        chk(hits, exp);
    endtask : flags
    // wait for transmit, then the byte under transmit, one idle or hold cycle, release
    task automatic send_chk(input logic [7:0] b, input logic [1:0] after);
        n = 0;
        while (!(ctl_oe === 1'b1 && ctl_out === phy_link_pkg::CTL_XMIT)) tick();
        tick();
        chk({data_oe, ctl_out, dat_out}, {1'b1, phy_link_pkg::CTL_XMIT, b});
        tick();
        chk({ctl_oe, ctl_out}, {1'b1, after});
        tick();
        chk(ctl_oe, 1'b0);
    endtask : send_chk
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        apb(1'b0, phy_link_pkg::REG_PHYREG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        flags(16'h0005, 2, 4'h5);
        apb(1'b0, phy_link_pkg::REG_STATUS, 32'h0);
        chk(rd[4:0], 5'h05);
        apb(1'b1, phy_link_pkg::REG_STATUS, 32'h7f);
        flags(16'h000a, 2, 4'ha);
        apb(1'b1, phy_link_pkg::REG_STATUS, 32'h7f);
        flags(16'hc360, 8, 4'h0);
        apb(1'b0, phy_link_pkg::REG_PHYREG, 32'h0);
        chk(rd[15:0], 16'hc306);
        apb(1'b0, phy_link_pkg::REG_STATUS, 32'h0);
        chk(rd[4], 1'b1);
        // one granted packet, straight to transmit and then with hold first
        for (int h = 0; h < 2; h++) begin
            apb(1'b1, phy_link_pkg::REG_CTRL, {30'h0, h[0], 1'b0});
            apb(1'b1, phy_link_pkg::REG_TXCTL, 32'h0000093c);
            u_phy_model.grant();
            n = 0;
            while (ctl_oe !== 1'b1) tick();
            chk(ctl_out, h[0] ? phy_link_pkg::CTL_HOLD : phy_link_pkg::CTL_XMIT);
            send_chk(8'h3c, phy_link_pkg::CTL_IDLE);
        end
        // two packets, each with its own grant, hold between them, one speed
        apb(1'b1, phy_link_pkg::REG_CTRL, 32'h0);
        apb(1'b1, phy_link_pkg::REG_TXCTL, 32'h00000b5a);
        u_phy_model.grant();
        send_chk(8'h5a, phy_link_pkg::CTL_HOLD);
        apb(1'b1, phy_link_pkg::REG_TXCTL, 32'h000009c3);
        u_phy_model.grant();
        send_chk(8'hc3, phy_link_pkg::CTL_IDLE);
        // each valid speed code, followed by one data byte
        for (int s = 0; s < 3; s++) begin
            u_phy_model.rx(s == 0 ? 8'h00 : (s == 1 ? 8'h40 : 8'h50), {4'ha, 2'h0, s[1:0]});
            repeat (3) @(posedge sys_clk);
            apb(1'b0, phy_link_pkg::REG_STATUS, 32'h0);
            chk(rd[9:8], s[1:0]);
            apb(1'b0, phy_link_pkg::REG_RXDATA, 32'h0);
            chk(rd[7:0], {4'ha, 2'h0, s[1:0]});
        end
        report_and_stop();
    end
endmodule : tb_top
